// file: logic/conv_seq_defs.svh
// Register offsets, field positions, reset values and timing counts for the convert sequencer
// Functional notes
// [R1] Each accepted convert pulse starts exactly one conversion; a sample holds one or more.
// [R2] Convert source selectable internal or external; active edge selectable rising or falling.
// [R3] Internal convert source is counter zero output or the divided convert timebase.
// [R4] Convert timebase comes from sample timebase or root timebase; never driven out.
// [R5] Divide counter starts on sample pulse, reloads, runs until sample ends, then waits.
// [R6] External convert source is any function input pin or sync lines 0 to 6.
// [R7] Convert pin in output mode reflects active convert pulse whatever its source.
// [R8] Convert pin starts as input and drives nothing until software selects output.
// [R9] Internal convert waits programmable timebase ticks after sample pulse; default two. The counter zero source skips this wait.
// [R10] Sample and convert pulses are ignored until an acquisition start trigger is seen.
// [R11] After a sample pulse, further sample pulses are dropped until all converts arrive.
// [R12] Convert pulses before any accepted sample pulse are dropped.
// [R13] After the configured convert count, further convert pulses are dropped until next sample.
// [R14] Root timebase is internal fast timebase or external sync line 7.
// [R15] Root timebase reaches a pin only through the general counters, never directly.
// [R16] Hold-done pulse, selectable polarity, starts 50-100 ns after conversion, lasts 400-500 ns.
// [R17] Strobe has software level mode and hardware burst of eight pulses, 10 ms or fast clock.
// [R18] Convert count per sample equals scan list length.
// [R19] Divide, delay and per-sample convert counts are software-writable fields.
`ifndef CONV_SEQ_DEFS_SVH
`define CONV_SEQ_DEFS_SVH

`define OFS_CTRL        12'h000
`define OFS_DIVIDE      12'h004
`define OFS_DELAY       12'h008
`define OFS_SCAN_LEN    12'h00C
`define OFS_STROBE      12'h010
`define OFS_STATUS      12'h014

`define CTRL_ARM        0
`define CTRL_CONV_EXT   1
`define CTRL_CONV_FALL  2
`define CTRL_CTR0_SEL   3
`define CTRL_TB_ROOT    4
`define CTRL_ROOT_EXT   5
`define CTRL_PIN_OUT    6
`define CTRL_HOLD_EN    7
`define CTRL_HOLD_POL   8
`define CTRL_EXT_LSB    9
`define CTRL_EXT_MSB    12

`define STB_LEVEL       0
`define STB_HW          1
`define STB_SLOW        2
`define STB_GO          3

`define CTRL_RESET      32'h0000_0000
`define DIVIDE_RESET    16'h0001
`define DELAY_RESET     16'h0002
`define SCAN_RESET      8'h01

`define CLK_NS          40
`define HOLD_LEAD_NS    50
`define HOLD_WIDTH_NS   400
`define HOLD_LEAD_CYC   ((`HOLD_LEAD_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_WIDTH_CYC  ((`HOLD_WIDTH_NS + `CLK_NS - 1) / `CLK_NS)
`define STB_FAST_NS     1200
`define STB_FAST_CYC    (`STB_FAST_NS / `CLK_NS)
`define STB_SLOW_MS     10
`define STB_SLOW_CYC    (`STB_SLOW_MS * 1000000 / `CLK_NS)
`define STB_PULSES      8

`endif

// file: logic/conv_seq_pkg.sv
// Types for the convert sequencer
package conv_seq_pkg;
	typedef enum logic [2:0]
	{
		st_idle    = 3'b001,
		st_wait    = 3'b010,
		st_convert = 3'b100
	} seq_state_e;

	typedef struct packed
	{
		logic [31:0] haddr;
		logic        hwrite;
		logic        hsel;
		logic [1:0]  htrans;
	} ahb_addr_s;

	typedef struct packed
	{
		logic        sample;
		logic        convert;
	} pulse_pair_s;
endpackage

// file: logic/edge_pick.sv
// Synchroniser with selectable edge detector
`timescale 1ns/1ps
module edge_pick
(
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Signal in
	input  wire logic din,
	input  wire logic falling,
	// Edge out
	output logic      pulse
);
	logic s1;
	logic s2;
	logic s3;

	assign pulse = falling ? (s3 & ~s2) : (s2 & ~s3);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end
endmodule

// file: logic/conv_clock_seq.sv
// Convert clock sequencer with AHB-Lite register slave
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "conv_seq_defs.svh"
module conv_clock_seq
	import conv_seq_pkg::*;
#(
	parameter int STB_SLOW_COUNT = `STB_SLOW_CYC
)
(
	// AHB-Lite
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic [2:0]  hsize,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Timebases and triggers
	input  wire logic        internal_fast_timebase,
	input  wire logic        sync_line7,
	input  wire logic        sample_timebase,
	input  wire logic        sample_pulse,
	input  wire logic        acq_start_trigger,
	input  wire logic        counter_zero_output,
	// External convert sources
	input  wire logic [7:0]  programmable_function_input,
	input  wire logic [6:0]  sync_lines,
	// Convert pin
	input  wire logic        conv_pulse_pin_in,
	output logic             conv_pulse_pin_out,
	output logic             conv_pulse_pin_oe,
	// Results
	output logic             conv_pulse,
	output logic             root_timebase,
	output logic             hold_done_pulse,
	output logic             strobe_out_pin,
	output logic             sample_busy
);
	// Register state
	logic [31:0] ctrl;
	logic [15:0] divide;
	logic [15:0] delay;
	logic [7:0]  scan_len;
	logic [3:0]  strobe_ctrl;
	logic        armed;
	ahb_addr_s   aph;
	logic        aph_valid;

	// Bus decode
	wire         bus_take = hsel & hready & htrans[1];
	wire         wr_now   = aph_valid & aph.hwrite;
	wire [11:0]  wofs     = aph.haddr[11:0];
	wire         mapped   = (aph.haddr[31:12] == 20'h0_0000);
	wire         wr_ctrl  = wr_now & mapped & (wofs == `OFS_CTRL);
	wire         wr_div   = wr_now & mapped & (wofs == `OFS_DIVIDE);
	wire         wr_dly   = wr_now & mapped & (wofs == `OFS_DELAY);
	wire         wr_scan  = wr_now & mapped & (wofs == `OFS_SCAN_LEN);
	wire         wr_stb   = wr_now & mapped & (wofs == `OFS_STROBE);
	wire [11:0]  rofs     = haddr[11:0];
	wire         rmapped  = (haddr[31:12] == 20'h0_0000);

	// Control fields
	wire         conv_ext  = ctrl[`CTRL_CONV_EXT];
	wire         conv_fall = ctrl[`CTRL_CONV_FALL];
	wire         ctr0_sel  = ctrl[`CTRL_CTR0_SEL];
	wire         tb_root   = ctrl[`CTRL_TB_ROOT];
	wire         root_ext  = ctrl[`CTRL_ROOT_EXT];
	wire [3:0]   ext_sel   = ctrl[`CTRL_EXT_MSB:`CTRL_EXT_LSB];

	// Source selection
	wire         root_raw  = root_ext ? sync_line7 : internal_fast_timebase; // [R14]
	wire         tb_raw    = tb_root ? root_raw : sample_timebase; // [R4]
	wire         ext_raw   = ext_sel[3] ? sync_lines[ext_sel[2:0] == 3'h7 ? 3'h6 : ext_sel[2:0]]
	                                    : programmable_function_input[ext_sel[2:0]]; // [R6]
	wire         tb_tick;
	wire         ext_edge;
	wire         ctr0_edge;
	wire         samp_edge;
	wire         trig_edge;

	edge_pick u_tb (.hclk(hclk), .hresetn(hresetn), .din(tb_raw), .falling(1'b0),
		.pulse(tb_tick));
	edge_pick u_ext (.hclk(hclk), .hresetn(hresetn), .din(ext_raw), .falling(conv_fall),
		.pulse(ext_edge)); // [R2]
	edge_pick u_ctr0 (.hclk(hclk), .hresetn(hresetn), .din(counter_zero_output),
		.falling(conv_fall), .pulse(ctr0_edge));
	edge_pick u_samp (.hclk(hclk), .hresetn(hresetn), .din(sample_pulse), .falling(1'b0),
		.pulse(samp_edge));
	edge_pick u_trig (.hclk(hclk), .hresetn(hresetn), .din(acq_start_trigger),
		.falling(1'b0), .pulse(trig_edge));

	// Sequencer
	seq_state_e  state;
	seq_state_e  next_state;
	logic [15:0] div_cnt;
	logic [7:0]  conv_cnt;
	wire         last_div  = (div_cnt <= 16'h0001);
	wire         int_edge  = ctr0_sel ? ctr0_edge : (tb_tick & last_div); // [R3]
	wire         in_conv   = (state == st_convert);
	wire         src_edge  = conv_ext ? ext_edge : (ctr0_sel ? ctr0_edge : int_edge);
	wire         accept    = in_conv & src_edge; // [R12] [R13]
	wire         last_conv = accept & (conv_cnt == scan_len - 8'h01); // [R18]
	wire         samp_ok   = armed & samp_edge & (state == st_idle); // [R10] [R11]
	wire         wait_done = (state == st_wait) & (conv_ext | ctr0_sel | (tb_tick & last_div));

	always_comb
	begin
		next_state = state;
		case (state)
			st_idle:    if (samp_ok) next_state = st_wait;
			st_wait:    if (wait_done) next_state = st_convert; // [R9]
			st_convert: if (last_conv) next_state = st_idle;
			default:    next_state = st_idle;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state    <= st_idle;
			div_cnt  <= `DELAY_RESET;
			conv_cnt <= 8'h00;
		end
		else
		begin
			state <= next_state;
			if (samp_ok)
				div_cnt <= delay; // [R5] [R9]
			else if (tb_tick & (state != st_idle))
				div_cnt <= last_div ? divide : div_cnt - 16'h0001; // [R5]
			else if (state == st_idle)
				div_cnt <= delay;
			if (samp_ok)
				conv_cnt <= 8'h00;
			else if (accept)
				conv_cnt <= conv_cnt + 8'h01;
		end
	end

	// Hold-done and convert outputs
	logic [4:0]  hold_cnt;
	wire         hold_fire = (hold_cnt >= 5'(`HOLD_LEAD_CYC))
	                       & (hold_cnt < 5'(`HOLD_LEAD_CYC + `HOLD_WIDTH_CYC));

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hold_cnt           <= 5'h00;
			conv_pulse         <= 1'b0;
			conv_pulse_pin_out <= 1'b0;
			conv_pulse_pin_oe  <= 1'b0; // [R8]
			hold_done_pulse    <= 1'b0;
			root_timebase      <= 1'b0;
			sample_busy        <= 1'b0;
		end
		else
		begin
			if (accept)
				hold_cnt <= 5'h01;
			else if (hold_cnt != 5'h00 && hold_cnt <= 5'(`HOLD_LEAD_CYC + `HOLD_WIDTH_CYC))
				hold_cnt <= hold_cnt + 5'h01;
			else
				hold_cnt <= 5'h00;
			conv_pulse         <= accept; // [R1]
			conv_pulse_pin_out <= accept; // [R7]
			conv_pulse_pin_oe  <= ctrl[`CTRL_PIN_OUT];
			hold_done_pulse    <= ctrl[`CTRL_HOLD_POL] ^
			                      (ctrl[`CTRL_HOLD_EN] & hold_fire); // [R16]
			root_timebase      <= root_raw; // [R15]
			sample_busy        <= (state != st_idle);
		end
	end

	// Strobe generator
	logic [23:0] stb_tmr;
	logic [4:0]  stb_edges;
	wire [23:0]  stb_half = strobe_ctrl[`STB_SLOW] ? 24'(STB_SLOW_COUNT / 2)
	                                               : 24'(`STB_FAST_CYC / 2);
	// Start request decoded from the write itself, so it is not lost to the old mode
	wire         stb_go      = wr_stb & hwdata[`STB_HW] & hwdata[`STB_GO];
	wire [23:0]  stb_go_half = hwdata[`STB_SLOW] ? 24'(STB_SLOW_COUNT / 2)
	                                             : 24'(`STB_FAST_CYC / 2);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stb_tmr        <= 24'h00_0000;
			stb_edges      <= 5'h00;
			strobe_out_pin <= 1'b0;
		end
		else if (stb_go)
		begin
			stb_tmr        <= stb_go_half;
			stb_edges      <= 5'(2 * `STB_PULSES);
			strobe_out_pin <= 1'b0;
		end
		else if (!strobe_ctrl[`STB_HW])
		begin
			stb_edges      <= 5'h00;
			strobe_out_pin <= strobe_ctrl[`STB_LEVEL]; // [R17]
		end
		else if (stb_edges != 5'h00)
		begin
			if (stb_tmr <= 24'h00_0001)
			begin
				stb_tmr        <= stb_half;
				stb_edges      <= stb_edges - 5'h01;
				strobe_out_pin <= ~strobe_out_pin; // [R17]
			end
			else
				stb_tmr <= stb_tmr - 24'h00_0001;
		end
	end

	// Registers and arm
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl        <= `CTRL_RESET;
			divide      <= `DIVIDE_RESET;
			delay       <= `DELAY_RESET;
			scan_len    <= `SCAN_RESET;
			strobe_ctrl <= 4'h0;
			armed       <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= {19'h0_0000, hwdata[12:0]};
			if (wr_div)
				divide <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0]; // [R19]
			if (wr_dly)
				delay <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0]; // [R19]
			if (wr_scan)
				scan_len <= (hwdata[7:0] == 8'h00) ? 8'h01 : hwdata[7:0]; // [R19]
			if (wr_stb)
				strobe_ctrl <= {1'b0, hwdata[2:0]};
			if (!ctrl[`CTRL_ARM])
				armed <= 1'b0;
			else if (trig_edge)
				armed <= 1'b1; // [R10]
		end
	end

	// AHB-Lite slave, zero wait states
	wire [31:0] rd_mux =
		!rmapped                ? 32'h0000_0000 :
		(rofs == `OFS_CTRL)     ? ctrl :
		(rofs == `OFS_DIVIDE)   ? {16'h0000, divide} :
		(rofs == `OFS_DELAY)    ? {16'h0000, delay} :
		(rofs == `OFS_SCAN_LEN) ? {24'h00_0000, scan_len} :
		(rofs == `OFS_STROBE)   ? {28'h000_0000, strobe_ctrl[2:0] == 3'h0 ? 1'b0 : 1'b0,
		                           strobe_ctrl[2:0]} :
		(rofs == `OFS_STATUS)   ? {16'h0000, conv_cnt, 3'h0, (stb_edges != 5'h00),
		                           armed, state} :
		                          32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			aph       <= '0;
			aph_valid <= 1'b0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			aph_valid <= bus_take;
			aph       <= '{haddr: haddr, hwrite: hwrite, hsel: hsel, htrans: htrans};
			hrdata    <= (bus_take & ~hwrite) ? rd_mux : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
endmodule

// file: dv/conv_clock_seq_checker.sv
// Port assertions for the convert sequencer
`timescale 1ns/1ps
module conv_clock_seq_checker
#(
	parameter int STB_SLOW_COUNT = 16
)
(
	// Bus
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic        hready,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hrdata,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	// Convert side
	input  wire logic        conv_pulse,
	input  wire logic        conv_pulse_pin_out,
	input  wire logic        conv_pulse_pin_oe,
	input  wire logic        sample_busy
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire rd_req = hsel && hready && htrans[1] && !hwrite;
	sequence recent_conv;
		conv_pulse || $past(conv_pulse) || $past(conv_pulse, 2);
	endsequence
	AST_READY: assert property (hreadyout)
		else $error("slave stalled");
	AST_OKAY: assert property (!hresp)
		else $error("error response");
	AST_IDLE_DATA: assert property (!rd_req |=> hrdata == 32'h0)
		else $error("read data outside read");
	AST_PIN_MIRROR: assert property (conv_pulse_pin_oe |-> conv_pulse_pin_out == conv_pulse)
		else $error("pin differs from convert pulse");
	AST_PIN_INPUT: assert property ($rose(hresetn) |-> !conv_pulse_pin_oe)
		else $error("pin driven after reset");
	AST_ONE_SHOT: assert property (conv_pulse |=> !conv_pulse)
		else $error("convert pulse too long");
	AST_GATED: assert property (conv_pulse |-> sample_busy || $past(sample_busy))
		else $error("convert outside sample");
	AST_BUSY_END: assert property ($fell(sample_busy) |-> recent_conv)
		else $error("sample ended without convert");
endmodule

bind conv_clock_seq conv_clock_seq_checker #(.STB_SLOW_COUNT(STB_SLOW_COUNT)) chk_i
(
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hready(hready), .htrans(htrans),
	.hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.conv_pulse(conv_pulse), .conv_pulse_pin_out(conv_pulse_pin_out),
	.conv_pulse_pin_oe(conv_pulse_pin_oe), .sample_busy(sample_busy)
);

// file: dv/conv_far_side.sv
// Far side model: trigger source, external convert source and converter
`timescale 1ns/1ps
module conv_far_side
(
	// Clock
	input  wire logic       hclk,
	// From the sequencer
	input  wire logic       conv_pulse,
	input  wire logic       hold_done_pulse,
	// To the sequencer
	output logic            sample_pulse,
	output logic            acq_start_trigger,
	output logic [7:0]      ext_in,
	output logic [6:0]      sync_out
);
	int seen = 0;
	int run = 0;
	int hold_w = 0;
	initial
	begin
		{sample_pulse, acq_start_trigger} = 2'h0;
		ext_in = 8'h0;
		sync_out = 7'h0;
	end
	// One conversion per convert pulse
	always @(posedge hclk)
		seen <= seen + (conv_pulse ? 1 : 0);
	// Width of the last hold pulse
	always @(posedge hclk)
	begin
		run <= hold_done_pulse ? run + 1 : 0;
		if (!hold_done_pulse && run != 0)
			hold_w <= run;
	end
	// Pulses: 0 sample, 1 start trigger, 2 external convert on input 3
	task automatic blip(input int sel, input int n);
		repeat (n)
		begin
			sample_pulse <= sel == 0;
			acq_start_trigger <= sel == 1;
			ext_in[3] <= sel == 2;
			repeat (4) @(posedge hclk);
			{sample_pulse, acq_start_trigger, ext_in[3]} <= 3'h0;
			repeat (12) @(posedge hclk);
		end
	endtask
endmodule

// file: dv/ai_convert_clock_sequencer_tb.sv
// Self-checking bench for the convert sequencer
`timescale 1ns/1ps
`include "conv_seq_defs.svh"
module ai_convert_clock_sequencer_tb;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        sample_pulse;
	logic        acq_start_trigger;
	logic [7:0]  ext_in;
	logic [6:0]  sync_out;
	logic        conv_pulse;
	logic        pin_out;
	logic        pin_oe;
	logic        hold_done_pulse;
	logic        strobe_out_pin;
	logic [3:0]  tb_cnt = 4'h0;
	logic        stb_q = 1'b0;
	logic [31:0] rd;
	logic [31:0] ofs [6] = '{`OFS_CTRL, `OFS_DIVIDE, `OFS_DELAY, `OFS_SCAN_LEN, `OFS_STROBE, 32'h20};
	logic [31:0] rst [6] = '{`CTRL_RESET, `DIVIDE_RESET, `DELAY_RESET, `SCAN_RESET, 32'h0, 32'h0};
	int          err_count = 0;
	int          n_tests = 0;
	int          stb_n = 0;
	int          cyc = 0;
	int          base;

	conv_clock_seq #(.STB_SLOW_COUNT(16)) conv_clock_seq_i
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hsize(3'h2), .hwrite(hwrite), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.internal_fast_timebase(tb_cnt[1]), .sync_line7(tb_cnt[3]),
		.sample_timebase(tb_cnt[2]), .sample_pulse(sample_pulse),
		.acq_start_trigger(acq_start_trigger), .counter_zero_output(1'b0),
		.programmable_function_input(ext_in), .sync_lines(sync_out),
		.conv_pulse_pin_in(1'b0), .conv_pulse_pin_out(pin_out), .conv_pulse_pin_oe(pin_oe),
		.conv_pulse(conv_pulse), .root_timebase(), .hold_done_pulse(hold_done_pulse),
		.strobe_out_pin(strobe_out_pin), .sample_busy()
	);

	conv_far_side far_i
	(
		.hclk(hclk), .conv_pulse(conv_pulse), .hold_done_pulse(hold_done_pulse),
		.sample_pulse(sample_pulse), .acq_start_trigger(acq_start_trigger),
		.ext_in(ext_in), .sync_out(sync_out)
	);

	initial
	begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	always @(posedge hclk)
	begin
		tb_cnt <= tb_cnt + 4'h1;
		stb_q <= strobe_out_pin;
		stb_n <= stb_n + ((strobe_out_pin && !stb_q) ? 1 : 0);
		cyc <= cyc + 1;
	end

	always @(posedge hclk)
		if (cyc == 5000)
		begin
			err_count++;
			summarize;
		end

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic summarize;
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		{hresetn, hsel, hwrite} = 3'h0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 6; i++)
		begin
			bus(1'b0, ofs[i], 32'h0);
			chk(rd, rst[i]);
		end
		chk({31'h0, pin_oe}, 32'h0);
		bus(1'b1, `OFS_DIVIDE, 32'h2);
		bus(1'b1, `OFS_SCAN_LEN, 32'h3);
		bus(1'b0, `OFS_SCAN_LEN, 32'h0);
		chk(rd, 32'h3);
		// Not armed
		base = far_i.seen;
		far_i.blip(0, 2);
		chk(far_i.seen - base, 32'h0);
		// Internal divided mode, second sample falls inside the first
		bus(1'b1, `OFS_CTRL, 32'h0C1);
		far_i.blip(1, 1);
		chk({31'h0, pin_oe}, 32'h1);
		base = far_i.seen;
		far_i.blip(0, 2);
		repeat (100) @(posedge hclk);
		chk(far_i.seen - base, 32'h3);
		chk(far_i.hold_w, 32'hA);
		// External falling edge on function input 3
		bus(1'b1, `OFS_CTRL, 32'h6C7);
		base = far_i.seen;
		far_i.blip(2, 2);
		far_i.blip(0, 1);
		far_i.blip(2, 5);
		chk(far_i.seen - base, 32'h3);
		// Strobe level, then fast and slow bursts
		bus(1'b1, `OFS_STROBE, 32'h1);
		repeat (2) @(posedge hclk);
		chk({31'h0, strobe_out_pin}, 32'h1);
		for (int i = 0; i < 2; i++)
		begin
			bus(1'b1, `OFS_STROBE, 32'h0);
			base = stb_n;
			bus(1'b1, `OFS_STROBE, i ? 32'hE : 32'hA);
			repeat (400) @(posedge hclk);
			chk(stb_n - base, 32'h8);
		end
		summarize;
	end
endmodule
